// File: hw/agm_address_gen.sv
// Address generator with circular buffer and bit-reversed write addressing
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "agm_defs.svh"
module agm_address_gen
  import agm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic req_i,
  input wire agm_class_t op_class_i,
  input wire agm_mode_t src_mode_i,
  input wire logic [3:0] src_ptr_i,
  input wire agm_mode_t dst_mode_i,
  input wire logic [3:0] dst_ptr_i,
  input wire logic [3:0] offset_reg_i,
  input wire logic [15:0] literal_i,
  input wire logic [1:0] mac_step_i,
  input wire logic byte_i,
  input wire logic branch_i,
  output logic ea_valid_o,
  output logic [15:0] src_ea_o,
  output logic src_yspace_o,
  output logic [15:0] dst_ea_o,
  output logic dst_yspace_o,
  output logic dst_write_o,
  output logic [15:0] literal_o,
  output logic fault_o
);

  // Reverse the bit order of a word
  function automatic logic [15:0] bit_rev16(input logic [15:0] a);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) begin
      r[i] = a[15 - i];
    end
    return r;
  endfunction : bit_rev16

  // Reverse-carry add: both the pointer and the modifier are bit-reversed before the add
  function automatic logic [15:0] rev_add(input logic [15:0] a, input logic [15:0] m);
    return bit_rev16(bit_rev16(a) + bit_rev16(m));
  endfunction : rev_add

  // Circular correction; range compares catch steps that jump past a boundary
  function automatic logic [15:0] mod_fix(input logic [15:0] a, input logic [15:0] s,
                                          input logic [15:0] e, input logic up);
    logic [16:0] len;
    logic pow2;
    logic [15:0] r;
    len = {1'b0, e} - {1'b0, s} + 17'h00001;
    pow2 = ((len & (len - 17'h00001)) == 17'h00000);
    r = a;
    if ((up || pow2) && (a > e)) begin
      r = a - len[15:0];
    end else if ((!up || pow2) && (a < s)) begin
      r = a + len[15:0];
    end
    return r;
  endfunction : mod_fix

  // Effective address and pointer update for one operand
  function automatic agm_res_t gen_ea(input agm_mode_t md, input logic [15:0] ptr,
                                      input logic [15:0] off, input logic [15:0] lit,
                                      input logic [15:0] step, input logic mod_on,
                                      input logic [15:0] ms, input logic [15:0] me,
                                      input logic word_only, input logic brev_on,
                                      input logic [14:0] xb);
    agm_res_t r;
    logic [15:0] sum;
    logic up;
    logic modify;
    r.ea = ptr;
    r.ptr = ptr;
    r.wb = 1'b0;
    r.bad = 1'b0;
    sum = ptr;
    up = 1'b1;
    modify = 1'b0;
    case (md)
      AGM_M_DIRECT, AGM_M_IND: r.ea = ptr;
      AGM_M_FILE, AGM_M_LIT16: r.ea = lit;
      AGM_M_LIT8: r.ea = {8'h00, lit[7:0]};
      AGM_M_POSTINC, AGM_M_PREINC: begin
        sum = ptr + step;
        modify = 1'b1;
      end
      AGM_M_POSTDEC, AGM_M_PREDEC: begin
        sum = ptr - step;
        up = 1'b0;
        modify = 1'b1;
      end
      AGM_M_INDEXED: begin
        sum = ptr + off;
        up = !off[15];
      end
      AGM_M_LITOFF: begin
        sum = ptr + lit;
        up = !lit[15];
      end
      default: r.bad = 1'b1;
    endcase
    if (mod_on && (modify || md == AGM_M_INDEXED || md == AGM_M_LITOFF)) begin
      sum = mod_fix(sum, ms, me, up);
    end
    if (brev_on) begin
      sum = rev_add(ptr, {xb, 1'b0});
    end
    if (modify) begin
      r.ptr = sum;
      r.wb = 1'b1;
      r.ea = (md == AGM_M_PREINC || md == AGM_M_PREDEC) ? sum : ptr;
    end else if (md == AGM_M_INDEXED || md == AGM_M_LITOFF) begin
      r.ea = sum;
    end
    if (word_only || brev_on) begin
      r.ea[0] = 1'b0;
      r.ptr[0] = 1'b0;
    end
    return r;
  endfunction : gen_ea

  // Configuration registers
  logic [15:0] mode_ctl;
  logic [15:0] x_start;
  logic [15:0] x_end;
  logic [15:0] y_start;
  logic [15:0] y_end;
  logic [15:0] brev_ctl;
  logic [15:0] w_file [16];
  logic last_fault;
  logic last_brev;

  // Bus decode
  logic wreg_hit;
  assign wreg_hit = ((reg_addr_i & `AGM_WREG_MASK) == `AGM_OFF_WREG);

  // Start keeps bit 0 low and end keeps it high so lengths are whole words
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_ctl <= `AGM_MODE_RST;
      x_start <= `AGM_START_RST;
      x_end <= `AGM_END_RST;
      y_start <= `AGM_START_RST;
      y_end <= `AGM_END_RST;
      brev_ctl <= `AGM_BREV_RST;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `AGM_OFF_MODE: mode_ctl <= reg_wdata_i & `AGM_MODE_MASK;
        `AGM_OFF_XSRT: x_start <= {reg_wdata_i[15:1], 1'b0};
        `AGM_OFF_XEND: x_end <= {reg_wdata_i[15:1], 1'b1};
        `AGM_OFF_YSRT: y_start <= {reg_wdata_i[15:1], 1'b0};
        `AGM_OFF_YEND: y_end <= {reg_wdata_i[15:1], 1'b1};
        `AGM_OFF_BREV: brev_ctl <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Mode decode from the control registers
  logic [3:0] x_sel;
  logic [3:0] y_sel;
  logic [3:0] b_sel;
  logic x_mod_on;
  logic y_mod_on;
  logic brev_cfg;
  assign x_sel = mode_ctl[`AGM_XSEL_LSB +: 4];
  assign y_sel = mode_ctl[`AGM_YSEL_LSB +: 4];
  assign b_sel = mode_ctl[`AGM_BSEL_LSB +: 4];
  assign x_mod_on = mode_ctl[`AGM_XEN_BIT] && (x_sel != `AGM_SEL_OFF);
  assign y_mod_on = mode_ctl[`AGM_YEN_BIT] && (y_sel != `AGM_SEL_OFF);
  assign brev_cfg = brev_ctl[`AGM_BIT_REVERSE_ENABLE_BIT] && (b_sel != `AGM_SEL_OFF);

  // Operand routing; X space also serves program-space pointers
  logic is_mac;
  logic src_y;
  logic dst_y;
  logic src_mod;
  logic dst_mod;
  logic dst_brev;
  logic [15:0] step;
  logic [15:0] off_val;
  assign is_mac = (op_class_i == AGM_C_MAC);
  assign src_y = is_mac && (src_ptr_i[3:1] == 3'b101);
  assign dst_y = is_mac && (dst_ptr_i[3:1] == 3'b101);
  assign off_val = w_file[offset_reg_i];
  assign step = is_mac ? {13'h0000, mac_step_i, 1'b0} : (byte_i ? 16'h0001 : 16'h0002);
  assign dst_brev = !is_mac && brev_cfg && (dst_ptr_i == b_sel) && !byte_i &&
                    (dst_mode_i == AGM_M_PREINC || dst_mode_i == AGM_M_POSTINC);
  assign src_mod = src_y ? (y_mod_on && src_ptr_i == y_sel) :
                           (x_mod_on && src_ptr_i == x_sel);
  assign dst_mod = dst_y ? (y_mod_on && dst_ptr_i == y_sel) :
                           (x_mod_on && dst_ptr_i == x_sel && !dst_brev);

  agm_res_t src_res;
  agm_res_t dst_res;
  assign src_res = gen_ea(src_mode_i, w_file[src_ptr_i], off_val, literal_i, step, src_mod,
                          src_y ? y_start : x_start, src_y ? y_end : x_end,
                          src_y && src_mod, 1'b0, brev_ctl[14:0]);
  assign dst_res = gen_ea(dst_mode_i, w_file[dst_ptr_i], off_val, literal_i, step, dst_mod,
                          dst_y ? y_start : x_start, dst_y ? y_end : x_end,
                          dst_y && dst_mod, dst_brev, brev_ctl[14:0]);

  // Mode legality per operation class
  function automatic logic mac_bad(input agm_mode_t md, input logic [3:0] p,
                                   input logic want_y, input logic [1:0] st);
    logic b;
    b = (p[3:2] != 2'b10) || (p[1] != want_y);
    if (!(md inside {AGM_M_IND, AGM_M_POSTINC, AGM_M_POSTDEC, AGM_M_INDEXED})) begin
      b = 1'b1;
    end
    if (md == AGM_M_INDEXED && !p[0]) begin
      b = 1'b1;
    end
    if ((md == AGM_M_POSTINC || md == AGM_M_POSTDEC) && st == 2'b00) begin
      b = 1'b1;
    end
    return b;
  endfunction : mac_bad

  logic fault;
  always_comb begin
    fault = 1'b0;
    unique case (op_class_i)
      AGM_C_MCU: begin
        fault = src_res.bad || dst_res.bad ||
                src_mode_i inside {AGM_M_INDEXED, AGM_M_LITOFF} ||
                dst_mode_i inside {AGM_M_INDEXED, AGM_M_LITOFF};
      end
      AGM_C_MOVACC: begin
        fault = src_res.bad || dst_res.bad ||
                dst_mode_i inside {AGM_M_LIT8, AGM_M_LIT16};
      end
      AGM_C_MAC: begin
        fault = mac_bad(src_mode_i, src_ptr_i, 1'b0, mac_step_i) ||
                mac_bad(dst_mode_i, dst_ptr_i, 1'b1, mac_step_i);
      end
      AGM_C_OTHER: fault = 1'b0;
    endcase
  end

  logic do_wb;
  assign do_wb = req_i && !fault && (op_class_i != AGM_C_OTHER);

  // Pointer file: update beats a bus write to the same register
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 16; i++) begin
        w_file[i] <= `AGM_WREG_RST;
      end
    end else begin
      if (reg_wr_i && wreg_hit) begin
        w_file[reg_addr_i[4:1]] <= reg_wdata_i;
      end
      if (do_wb && src_res.wb) begin
        w_file[src_ptr_i] <= src_res.ptr;
      end
      if (do_wb && dst_res.wb) begin
        w_file[dst_ptr_i] <= dst_res.ptr;
      end
    end
  end

  // Answer to the decoder, one cycle after the request
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ea_valid_o <= 1'b0;
      fault_o <= 1'b0;
      src_ea_o <= 16'h0000;
      dst_ea_o <= 16'h0000;
      src_yspace_o <= 1'b0;
      dst_yspace_o <= 1'b0;
      dst_write_o <= 1'b0;
      literal_o <= 16'h0000;
    end else begin
      ea_valid_o <= req_i;
      fault_o <= req_i && fault;
      if (req_i) begin
        src_ea_o <= src_res.ea;
        dst_ea_o <= dst_res.ea;
        src_yspace_o <= src_y;
        dst_yspace_o <= dst_y;
        dst_write_o <= !is_mac && (op_class_i != AGM_C_OTHER);
        // Interrupt-disable count is unsigned 14-bit; branch target passes whole
        literal_o <= (op_class_i == AGM_C_OTHER && !branch_i) ?
                     {2'b00, literal_i[13:0]} : literal_i;
      end
    end
  end

  // Status of the last request, readable by software
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      last_fault <= 1'b0;
      last_brev <= 1'b0;
    end else if (req_i) begin
      last_fault <= fault;
      last_brev <= dst_brev;
    end
  end

  // Read data one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      if (wreg_hit) begin
        reg_rdata_o <= w_file[reg_addr_i[4:1]];
      end else begin
        unique case (reg_addr_i)
          `AGM_OFF_MODE: reg_rdata_o <= mode_ctl;
          `AGM_OFF_XSRT: reg_rdata_o <= x_start;
          `AGM_OFF_XEND: reg_rdata_o <= x_end;
          `AGM_OFF_YSRT: reg_rdata_o <= y_start;
          `AGM_OFF_YEND: reg_rdata_o <= y_end;
          `AGM_OFF_BREV: reg_rdata_o <= brev_ctl;
          `AGM_OFF_STAT: reg_rdata_o <= {14'h0000, last_brev, last_fault};
          default: reg_rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  a_answer_timing: assert property (req_i |=> ea_valid_o ##1 !ea_valid_o || $past(req_i))
    else $error("answer not one cycle after request");
  a_mac_ptr_set: assert property (req_i && is_mac && src_ptr_i[3:2] != 2'b10 |=> fault_o)
    else $error("dual fetch pointer outside 8..11 accepted");
  a_mac_index: assert property (req_i && is_mac && src_mode_i == AGM_M_INDEXED &&
                                src_ptr_i == 4'h8 |=> fault_o)
    else $error("indexed dual fetch through pointer 8 accepted");
  a_y_route: assert property (req_i && is_mac && dst_ptr_i == 4'hA |=> dst_yspace_o)
    else $error("pointer 10 not routed to Y");
  a_y_word: assert property (ea_valid_o && dst_yspace_o && $past(dst_mod) |->
                             dst_ea_o[0] == 1'b0)
    else $error("Y circular address odd");
  a_lit8_zero: assert property (req_i && op_class_i == AGM_C_MOVACC &&
                                src_mode_i == AGM_M_LIT8 |=> src_ea_o[15:8] == 8'h00)
    else $error("8-bit literal not zero extended");
  a_interrupt_disable_op_width: assert property (req_i && op_class_i == AGM_C_OTHER && !branch_i |=>
                                 literal_o[15:14] == 2'b00)
    else $error("interrupt disable literal wider than 14 bits");
  a_xsel_off: assert property (req_i && x_sel == `AGM_SEL_OFF &&
                               op_class_i == AGM_C_MOVACC && src_mode_i == AGM_M_POSTINC &&
                               src_ptr_i != dst_ptr_i && !fault |=>
                               w_file[$past(src_ptr_i)] == $past(w_file[src_ptr_i] + step))
    else $error("X circular active with select 15");
  a_ymod_enable: assert property (req_i && is_mac && !mode_ctl[`AGM_YEN_BIT] &&
                                  dst_mode_i == AGM_M_POSTINC && !fault |=>
                                  w_file[$past(dst_ptr_i)] == $past(w_file[dst_ptr_i] + step))
    else $error("Y circular active without enable");
  a_brev_prio: assert property (dst_brev |-> !dst_mod)
    else $error("circular correction with bit reverse active");
  a_read_latency: assert property (reg_rd_i && reg_addr_i == `AGM_OFF_MODE |=>
                                   reg_rdata_o == $past(mode_ctl))
    else $error("control register read data wrong");

  c_mac_fetch: cover property (req_i && is_mac && !fault ##1 ea_valid_o);
  c_mod_wrap: cover property (req_i && src_mod && src_res.ptr < w_file[src_ptr_i] &&
                              src_mode_i == AGM_M_POSTINC);
  c_brev_write: cover property (req_i && dst_brev && !fault);

endmodule : agm_address_gen

// File: shared/agm_defs.svh
// Offsets, field positions, reset values and constants of the address generator
`ifndef AGM_DEFS_SVH
`define AGM_DEFS_SVH

// Register byte addresses, one 16-bit register per even address
`define AGM_OFF_MODE 8'h00
`define AGM_OFF_XSRT 8'h02
`define AGM_OFF_XEND 8'h04
`define AGM_OFF_YSRT 8'h06
`define AGM_OFF_YEND 8'h08
`define AGM_OFF_BREV 8'h0A
`define AGM_OFF_STAT 8'h0C
// Pointer file: sixteen registers at 0x20 + 2*n
`define AGM_OFF_WREG 8'h20
`define AGM_WREG_MASK 8'hE1

// Field positions of the addressing mode control register
`define AGM_XSEL_LSB 0
`define AGM_YSEL_LSB 4
`define AGM_BSEL_LSB 8
`define AGM_YEN_BIT 14
`define AGM_XEN_BIT 15
`define AGM_MODE_MASK 16'hCFFF
// Field positions of the bit-reverse control register
`define AGM_BIT_REVERSE_ENABLE_BIT 15

// Reset values
`define AGM_MODE_RST 16'h0000
`define AGM_START_RST 16'h0000
`define AGM_END_RST 16'h0001
`define AGM_BREV_RST 16'h0000
`define AGM_WREG_RST 16'h0000

// Pointer select value that means "off"
`define AGM_SEL_OFF 4'hF

`endif

// File: shared/agm_pkg.sv
// Types shared by the address generator
package agm_pkg;

  typedef enum logic [3:0] {
    AGM_M_DIRECT  = 4'h0,
    AGM_M_IND     = 4'h1,
    AGM_M_POSTINC = 4'h2,
    AGM_M_POSTDEC = 4'h3,
    AGM_M_PREINC  = 4'h4,
    AGM_M_PREDEC  = 4'h5,
    AGM_M_INDEXED = 4'h6,
    AGM_M_LITOFF  = 4'h7,
    AGM_M_LIT8    = 4'h8,
    AGM_M_LIT16   = 4'h9,
    AGM_M_FILE    = 4'hA
  } agm_mode_t;

  typedef enum logic [1:0] {
    AGM_C_MCU    = 2'h0,
    AGM_C_MOVACC = 2'h1,
    AGM_C_MAC    = 2'h2,
    AGM_C_OTHER  = 2'h3
  } agm_class_t;

  typedef struct packed {
    logic [15:0] ea;
    logic [15:0] ptr;
    logic wb;
    logic bad;
  } agm_res_t;

endpackage : agm_pkg

// File: testbench/address_generator_modulo_bench.sv
// Self-checking bench for the address generator
`timescale 1ns/1ps
`include "agm_defs.svh"
module address_generator_modulo_bench
  import agm_pkg::*;
;
  logic mclk_i;
  logic reset_i;
  logic [7:0] reg_addr_i;
  logic [15:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [15:0] reg_rdata_o;
  logic req_i;
  agm_class_t op_class_i;
  agm_mode_t src_mode_i;
  agm_mode_t dst_mode_i;
  logic [3:0] src_ptr_i;
  logic [3:0] dst_ptr_i;
  logic [3:0] offset_reg_i;
  logic [15:0] literal_i;
  logic [1:0] mac_step_i;
  logic byte_i;
  logic branch_i;
  logic ea_valid_o;
  logic [15:0] src_ea_o;
  logic src_yspace_o;
  logic [15:0] dst_ea_o;
  logic dst_yspace_o;
  logic dst_write_o;
  logic [15:0] literal_o;
  logic fault_o;
  logic [15:0] rd;
  int err_total;
  int n_compared;

  agm_address_gen u_agm_address_gen (.mclk_i(mclk_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .req_i(req_i), .op_class_i(op_class_i),
    .src_mode_i(src_mode_i), .src_ptr_i(src_ptr_i), .dst_mode_i(dst_mode_i),
    .dst_ptr_i(dst_ptr_i), .offset_reg_i(offset_reg_i), .literal_i(literal_i),
    .mac_step_i(mac_step_i), .byte_i(byte_i), .branch_i(branch_i), .ea_valid_o(ea_valid_o),
    .src_ea_o(src_ea_o), .src_yspace_o(src_yspace_o), .dst_ea_o(dst_ea_o),
    .dst_yspace_o(dst_yspace_o), .dst_write_o(dst_write_o), .literal_o(literal_o),
    .fault_o(fault_o));

  agm_decoder_model u_agm_decoder_model (.mclk_i(mclk_i), .req_o(req_i), .class_o(op_class_i),
    .src_mode_o(src_mode_i), .src_ptr_o(src_ptr_i), .dst_mode_o(dst_mode_i),
    .dst_ptr_o(dst_ptr_i), .offset_reg_o(offset_reg_i), .literal_o(literal_i),
    .mac_step_o(mac_step_i), .byte_o(byte_i), .branch_o(branch_i));

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : check16

  task automatic check1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : check1

  task automatic report_and_stop;
    if (err_total == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Bus cycles: one-cycle strobes, read data taken in the following cycle only
  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask : bus_rd

  // Pointer file sits at 0x20 + 2n
  task automatic set_ptr(input logic [3:0] n, input logic [15:0] v);
    bus_wr(`AGM_OFF_WREG + {3'b000, n, 1'b0}, v);
  endtask : set_ptr

  task automatic ptr_is(input logic [3:0] n, input logic [15:0] v);
    bus_rd(`AGM_OFF_WREG + {3'b000, n, 1'b0}, rd);
    check16(rd, v);
  endtask : ptr_is

  // Request then look at the answer one cycle later, where it stands
  task automatic rq(input agm_class_t c, input agm_mode_t sm, input logic [3:0] sp,
      input agm_mode_t dm, input logic [3:0] dp, input logic [15:0] lit = 16'h0000,
      input logic [3:0] off = 4'h0, input logic [1:0] st = 2'h0, input logic br = 1'b0);
    u_agm_decoder_model.issue(c, sm, sp, dm, dp, lit, off, st, br);
    #1;
    check1(ea_valid_o, 1'b1);
  endtask : rq

  task automatic t_regs;
    logic [15:0] rst_val [6] = '{16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0001, 16'h0000};
    check1(ea_valid_o, 1'b0);
    for (int i = 0; i < 6; i++) begin
      bus_rd(8'(2 * i), rd);
      check16(rd, rst_val[i]);
    end
    bus_rd(8'h10, rd);
    check16(rd, 16'h0000);
    bus_wr(`AGM_OFF_MODE, 16'hFFFF);
    bus_rd(`AGM_OFF_MODE, rd);
    check16(rd, 16'hCFFF);
    bus_wr(`AGM_OFF_XSRT, 16'h1235);
    bus_wr(`AGM_OFF_XEND, 16'h1234);
    bus_rd(`AGM_OFF_XSRT, rd);
    check16(rd, 16'h1234);
    bus_rd(`AGM_OFF_XEND, rd);
    check16(rd, 16'h1235);
  endtask : t_regs

  task automatic t_movacc;
    set_ptr(4'h1, 16'h0010);
    set_ptr(4'h3, 16'h0004);
    set_ptr(4'h0, 16'h0040);
    rq(AGM_C_MOVACC, AGM_M_POSTINC, 4'h1, AGM_M_DIRECT, 4'h0);
    check16(src_ea_o, 16'h0010);
    check16(dst_ea_o, 16'h0040);
    check1(dst_write_o, 1'b1);
    ptr_is(4'h1, 16'h0012);
    // Both operands indexed through the one shared offset field
    rq(AGM_C_MOVACC, AGM_M_INDEXED, 4'h1, AGM_M_INDEXED, 4'h0, 16'h0000, 4'h3);
    check1(fault_o, 1'b0);
    check16(src_ea_o, 16'h0016);
    check16(dst_ea_o, 16'h0044);
    ptr_is(4'h1, 16'h0012);
    rq(AGM_C_MOVACC, AGM_M_LIT8, 4'h0, AGM_M_DIRECT, 4'h0, 16'h12AB);
    check16(src_ea_o, 16'h00AB);
    rq(AGM_C_MOVACC, AGM_M_LIT16, 4'h0, AGM_M_DIRECT, 4'h0, 16'h12AB);
    check16(src_ea_o, 16'h12AB);
    rq(AGM_C_MCU, AGM_M_INDEXED, 4'h1, AGM_M_DIRECT, 4'h0, 16'h0000, 4'h3);
    check1(fault_o, 1'b1);
    rq(AGM_C_OTHER, AGM_M_DIRECT, 4'h0, AGM_M_DIRECT, 4'h0, 16'hFFFF);
    check16(literal_o, 16'h3FFF);
    rq(AGM_C_OTHER, AGM_M_DIRECT, 4'h0, AGM_M_DIRECT, 4'h0, 16'h8001, 4'h0, 2'h0, 1'b1);
    check16(literal_o, 16'h8001);
  endtask : t_movacc

  task automatic t_mac;
    logic [15:0] exp8;
    exp8 = 16'h0800;
    set_ptr(4'h8, 16'h0800);
    set_ptr(4'h9, 16'h0900);
    set_ptr(4'hA, 16'h0C00);
    for (int s = 1; s < 4; s++) begin
      rq(AGM_C_MAC, AGM_M_POSTINC, 4'h8, AGM_M_IND, 4'hA, 16'h0000, 4'h0, 2'(s));
      check1(fault_o, 1'b0);
      check16(src_ea_o, exp8);
      check1(src_yspace_o, 1'b0);
      check16(dst_ea_o, 16'h0C00);
      check1(dst_yspace_o, 1'b1);
      check1(dst_write_o, 1'b0);
      exp8 = exp8 + 16'(2 * s);
    end
    ptr_is(4'h8, exp8);
    rq(AGM_C_MAC, AGM_M_INDEXED, 4'h8, AGM_M_IND, 4'hA, 16'h0000, 4'h3);
    check1(fault_o, 1'b1);
    rq(AGM_C_MAC, AGM_M_INDEXED, 4'h9, AGM_M_INDEXED, 4'hB, 16'h0000, 4'h3);
    check1(fault_o, 1'b0);
    check16(src_ea_o, 16'h0904);
  endtask : t_mac

  task automatic t_xcirc;
    logic [15:0] ctl [3] = '{16'h8FF1, 16'h8FFF, 16'h0FF1};
    logic [15:0] nxt [3] = '{16'h0100, 16'h0108, 16'h0108};
    // Power-of-two buffer 0x100..0x107; pointer 1 chosen, never frame or stack
    bus_wr(`AGM_OFF_XSRT, 16'h0100);
    bus_wr(`AGM_OFF_XEND, 16'h0107);
    for (int i = 0; i < 3; i++) begin
      bus_wr(`AGM_OFF_MODE, ctl[i]);
      set_ptr(4'h1, 16'h0106);
      rq(AGM_C_MOVACC, AGM_M_POSTINC, 4'h1, AGM_M_DIRECT, 4'h0);
      check16(src_ea_o, 16'h0106);
      ptr_is(4'h1, nxt[i]);
    end
    bus_wr(`AGM_OFF_MODE, 16'h8FF1);
    set_ptr(4'h1, 16'h0100);
    rq(AGM_C_MOVACC, AGM_M_POSTDEC, 4'h1, AGM_M_DIRECT, 4'h0);
    ptr_is(4'h1, 16'h0106);
    rq(AGM_C_MOVACC, AGM_M_LITOFF, 4'h1, AGM_M_DIRECT, 4'h0, 16'h0004);
    check16(src_ea_o, 16'h0102);
    ptr_is(4'h1, 16'h0106);
  endtask : t_xcirc

  task automatic t_ycirc;
    bus_wr(`AGM_OFF_YSRT, 16'h0200);
    bus_wr(`AGM_OFF_YEND, 16'h0203);
    bus_wr(`AGM_OFF_MODE, 16'h4FAF);
    set_ptr(4'hA, 16'h0201);
    rq(AGM_C_MAC, AGM_M_IND, 4'h8, AGM_M_IND, 4'hA);
    check16(dst_ea_o, 16'h0200);
    set_ptr(4'hA, 16'h0202);
    rq(AGM_C_MAC, AGM_M_IND, 4'h8, AGM_M_POSTINC, 4'hA, 16'h0000, 4'h0, 2'h1);
    check16(dst_ea_o, 16'h0202);
    ptr_is(4'hA, 16'h0200);
    bus_wr(`AGM_OFF_MODE, 16'h0FAF);
    set_ptr(4'hA, 16'h0202);
    rq(AGM_C_MAC, AGM_M_IND, 4'h8, AGM_M_POSTINC, 4'hA, 16'h0000, 4'h0, 2'h1);
    ptr_is(4'hA, 16'h0204);
  endtask : t_ycirc

  task automatic t_brev;
    logic [15:0] seq [4] = '{16'h0000, 16'h0008, 16'h0004, 16'h000C};
    // Modifier 4 words is 8 bytes; pointer 2 takes reversed writes and X circular reads
    bus_wr(`AGM_OFF_MODE, 16'h82F2);
    bus_wr(`AGM_OFF_BREV, 16'h8004);
    set_ptr(4'h2, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      rq(AGM_C_MOVACC, AGM_M_DIRECT, 4'h0, AGM_M_POSTINC, 4'h2);
      check1(dst_write_o, 1'b1);
      check16(dst_ea_o, seq[i]);
    end
    ptr_is(4'h2, 16'h0002);
    bus_rd(`AGM_OFF_STAT, rd);
    check16(rd, 16'h0002);
    // The X read path still wraps in the 0x100..0x107 buffer while reversal is on
    set_ptr(4'h2, 16'h0106);
    rq(AGM_C_MOVACC, AGM_M_POSTINC, 4'h2, AGM_M_DIRECT, 4'h0);
    check16(src_ea_o, 16'h0106);
    ptr_is(4'h2, 16'h0100);
    rq(AGM_C_MOVACC, AGM_M_DIRECT, 4'h0, AGM_M_POSTDEC, 4'h2);
    ptr_is(4'h2, 16'h0106);
  endtask : t_brev

  // Free-running 100 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // Watchdog so a stuck sequence still ends with a verdict
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    err_total = 0;
    n_compared = 0;
    reset_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wdata_i = 16'h0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    repeat (8) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_regs();
    t_movacc();
    t_mac();
    t_xcirc();
    t_ycirc();
    t_brev();
    report_and_stop();
  end
endmodule : address_generator_modulo_bench

// File: testbench/agm_decoder_model.sv
// Decoder-side model that issues operand address requests
`timescale 1ns/1ps
module agm_decoder_model
  import agm_pkg::*;
(
  input wire logic mclk_i,
  output logic req_o,
  output agm_class_t class_o,
  output agm_mode_t src_mode_o,
  output logic [3:0] src_ptr_o,
  output agm_mode_t dst_mode_o,
  output logic [3:0] dst_ptr_o,
  output logic [3:0] offset_reg_o,
  output logic [15:0] literal_o,
  output logic [1:0] mac_step_o,
  output logic byte_o,
  output logic branch_o
);
  // Idle request fields; word accesses only, byte paths are out of scope here
  initial begin
    req_o = 1'b0;
    class_o = AGM_C_MCU;
    src_mode_o = AGM_M_DIRECT;
    src_ptr_o = 4'h0;
    dst_mode_o = AGM_M_DIRECT;
    dst_ptr_o = 4'h0;
    offset_reg_o = 4'h0;
    literal_o = 16'h0000;
    mac_step_o = 2'h0;
    byte_o = 1'b0;
    branch_o = 1'b0;
  end

  // One-cycle request pulse, all fields but byte_o launched with it after a rising edge
  task automatic issue(input agm_class_t c, input agm_mode_t sm, input logic [3:0] sp,
      input agm_mode_t dm, input logic [3:0] dp, input logic [15:0] lit = 16'h0000,
      input logic [3:0] off = 4'h0, input logic [1:0] st = 2'h0, input logic br = 1'b0);
    @(posedge mclk_i);
    req_o <= 1'b1;
    class_o <= c;
    src_mode_o <= sm;
    dst_mode_o <= dm;
    // Dual-fetch pointers come only from 8/9 (X) and 10/11 (Y)
    src_ptr_o <= (c == AGM_C_MAC) ? {3'b100, sp[0]} : sp;
    dst_ptr_o <= (c == AGM_C_MAC) ? {3'b101, dp[0]} : dp;
    offset_reg_o <= off;
    literal_o <= lit;
    mac_step_o <= st;
    branch_o <= br;
    @(posedge mclk_i);
    req_o <= 1'b0;
  endtask : issue
endmodule : agm_decoder_model
